/* File: rtl/seq_pkg.sv */
/*
 * Constants, types and map addresses shared by the offload-test sequencer.
 * Assumes the offload core and the pattern block share one register port.
 */
package seq_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam int unsigned TIMEOUT_MS = 100;
  localparam int unsigned TIMEOUT_TICKS = (TIMEOUT_MS * 1000) / TICK_US;

  // ****************************************
  // Widths and limits
  // ****************************************
  localparam int SIZE_W = 42;
  localparam int CNT_LO_W = 32;
  localparam int CNT_HI_W = 10;
  localparam int PKT_W = 16;
  localparam int NET_N = 7;
  localparam int AW = 16;
  localparam logic [PKT_W-1:0] PKT_MAX = 16'h2000;

  // ****************************************
  // Partner register map
  // ****************************************
  localparam logic [AW-1:0] CORE_RST = 16'h0000;
  localparam logic [AW-1:0] CORE_CMD = 16'h0004;
  localparam logic [AW-1:0] CORE_NET_BASE = 16'h0008;
  localparam logic [AW-1:0] CORE_PKL = 16'h0024;
  localparam logic [AW-1:0] CORE_TDL = 16'h0028;
  localparam logic [AW-1:0] CORE_TDH = 16'h002C;
  localparam logic [AW-1:0] USER_TXL = 16'h1000;
  localparam logic [AW-1:0] USER_TXH = 16'h1004;
  localparam logic [AW-1:0] USER_RST = 16'h1008;
  localparam logic [AW-1:0] USER_CMD = 16'h100C;
  localparam logic [AW-1:0] USER_RXL = 16'h1010;
  localparam logic [AW-1:0] USER_RXH = 16'h1014;
  localparam int BUSY_BIT = 0;
  localparam int VFAIL_BIT = 1;
  localparam logic [31:0] WORD_ONE = 32'h0000_0001;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] CMD_VERIFY = 32'h0000_0002;

  // ****************************************
  // Software register map (byte addresses)
  // ****************************************
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_SIZE_LO = 8'h04;
  localparam logic [7:0] WB_SIZE_HI = 8'h08;
  localparam logic [7:0] WB_PKT = 8'h0C;
  localparam logic [7:0] WB_NET_BASE = 8'h10;
  localparam logic [7:0] WB_NET_END = 8'h2C;
  localparam logic [7:0] WB_STATUS = 8'h2C;
  localparam logic [7:0] WB_IRQ_STAT = 8'h30;
  localparam logic [7:0] WB_IRQ_MASK = 8'h34;
  localparam logic [7:0] WB_TIMER = 8'h38;
  localparam int CTRL_VERIFY_BIT = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TMO = 1;
  localparam int IRQ_VFAIL = 2;
  localparam int IRQ_REJ = 3;
  localparam int IRQ_W = 4;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_INIT = 3'b001,
    OP_SEND = 3'b010,
    OP_RECV = 3'b011,
    OP_DUPLEX = 3'b100
  } op_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00000,
    S_RST_ON = 5'b00001,
    S_PARAM = 5'b00010,
    S_RST_OFF = 5'b00011,
    S_POLL_INIT = 5'b00100,
    S_U_TXL = 5'b00101,
    S_U_TXH = 5'b00110,
    S_U_RST = 5'b00111,
    S_U_CMD = 5'b01000,
    S_C_PKL = 5'b01001,
    S_C_TDL = 5'b01010,
    S_C_TDH = 5'b01011,
    S_C_SEND = 5'b01100,
    S_RD_BUSY = 5'b01101,
    S_RD_RXL = 5'b01110,
    S_RD_RXH = 5'b01111,
    S_CHECK = 5'b10000
  } seq_state_t;
endpackage : seq_pkg

/* File: rtl/reg_op_if.sv */
/*
 * One register access between the sequencer and its access engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface reg_op_if;
  import seq_pkg::*;
  logic req;
  logic we;
  logic [AW-1:0] addr;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;
  modport ctl (output req, we, addr, wdata, input done, rdata);
  modport exe (input req, we, addr, wdata, output done, rdata);
endinterface : reg_op_if

/* File: rtl/reg_access.sv */
/*
 * Access engine: turns a one-cycle request into a held partner access.
 * Assumes the partner answers with a one-cycle ack while req is high.
 */
`timescale 1ns/1ps
module reg_access (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Sequencer side
  reg_op_if.exe op,
  // Partner side
  output logic pa_req_o,
  output logic pa_we_o,
  output logic [seq_pkg::AW-1:0] pa_addr_o,
  output logic [31:0] pa_wdata_o,
  input wire logic [31:0] pa_rdata_i,
  input wire logic pa_ack_i
);
  import seq_pkg::*;

  typedef struct packed {
    logic req;
    logic we;
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic done;
    logic [31:0] rdata;
  } acc_t;

  acc_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (s_q.req && pa_ack_i) begin
      s_d.req = 1'b0;
      s_d.done = 1'b1;
      s_d.rdata = pa_rdata_i;
    end else if (!s_q.req && op.req) begin
      s_d.req = 1'b1;
      s_d.we = op.we;
      s_d.addr = op.addr;
      s_d.wdata = op.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pa_req_o = s_q.req;
  assign pa_we_o = s_q.we;
  assign pa_addr_o = s_q.addr;
  assign pa_wdata_o = s_q.wdata;
  assign op.done = s_q.done;
  assign op.rdata = s_q.rdata;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_req_held_stable: assert property (pa_req_o && !pa_ack_i |=> pa_req_o && $stable(pa_addr_o))
    else $error("partner request dropped before ack");
endmodule : reg_access

/* File: rtl/stall_timer.sv */
/*
 * Receive stall watch: samples the count each tick, flags a stall timeout.
 * Assumes count_i is updated by the sequencer with a one-cycle smp_i.
 */
`timescale 1ns/1ps
module stall_timer #(
  parameter int unsigned TICK_CYCLES = seq_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic active_i,
  input wire logic smp_i,
  input wire logic [seq_pkg::SIZE_W-1:0] count_i,
  output logic tmo_o
);
  import seq_pkg::*;

  typedef struct packed {
    logic [31:0] tick;
    logic [SIZE_W-1:0] latest;
    logic [SIZE_W-1:0] last;
    logic [15:0] stall;
    logic tmo;
  } stall_t;

  stall_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!active_i) begin
      s_d = '0;
    end else begin
      if (smp_i) begin
        s_d.latest = count_i;
      end
      if (s_q.tick == 32'(TICK_CYCLES - 1)) begin
        s_d.tick = '0;
        if (s_q.latest != s_q.last) begin
          s_d.last = s_q.latest;
          s_d.stall = '0;
        end else begin
          s_d.stall = s_q.stall + 16'h0001;
        end
        if (s_q.latest == s_q.last && s_q.stall == 16'(TIMEOUT_TICKS - 1)) begin
          s_d.tmo = 1'b1;
        end
      end else begin
        s_d.tick = s_q.tick + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tmo_o = s_q.tmo;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tmo_after_stall: assert property ($rose(tmo_o) |-> $past(s_q.stall) == 16'(TIMEOUT_TICKS - 1))
    else $error("timeout without full stall period");
  a_change_restart: assert property (
    active_i && s_q.tick == 32'(TICK_CYCLES - 1) && s_q.latest != s_q.last |=> s_q.stall == 16'h0000)
    else $error("stall count not restarted on change");
endmodule : stall_timer

/* File: rtl/udp_test_sequencer.sv */
/*
 * Offload-core test sequencer: re-init, send, receive and duplex runs,
 * steered from a classic Wishbone slave. Assumes the core and the pattern
 * block answer on one register port in this clock domain.
 */
// Behaviour
// - raise core reset bit first
// - write all network parameters under reset
// - clear core reset bit to start init
// - poll core busy until it reads zero
// - write packet and total lengths, then send
// - transmit ends only when busy reads zero
// - set user tx length, pulse pattern reset
// - user command 0 starts, 2 adds checking
// - data is 32-bit incrementing pattern
// - receive done when count equals size
// - receive times out after 100 ms stall
// - stop timer, read verify-fail bit
// - duplex ends when both directions end
// - duplex uses one size both ways
// - core receives while it transmits
`timescale 1ns/1ps
module udp_test_sequencer #(
  parameter int unsigned TICK_CYCLES = seq_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Partner register port
  output logic pa_req_o,
  output logic pa_we_o,
  output logic [seq_pkg::AW-1:0] pa_addr_o,
  output logic [31:0] pa_wdata_o,
  input wire logic [31:0] pa_rdata_i,
  input wire logic pa_ack_i,
  // Interrupt
  output logic irq_o
);
  import seq_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    seq_state_t st;
    op_t mode;
    logic verify;
    logic pend;
    logic [2:0] idx;
    logic op_req;
    logic op_we;
    logic [AW-1:0] op_addr;
    logic [31:0] op_wdata;
    logic tx_done;
    logic rx_done;
    logic rx_act;
    logic tmo;
    logic vfail;
    logic rej;
    logic [CNT_LO_W-1:0] rx_lo;
    logic [SIZE_W-1:0] rx_cnt;
    logic smp;
    logic [SIZE_W-1:0] size;
    logic [PKT_W-1:0] pkt;
    logic [NET_N-1:0][31:0] net;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic irq;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] timer;
    logic trun;
  } seq_st_t;

  seq_st_t s_q, s_d;
  reg_op_if op ();
  logic stall_tmo;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  reg_access u_access (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .op(op.ctl),
    .pa_req_o(pa_req_o),
    .pa_we_o(pa_we_o),
    .pa_addr_o(pa_addr_o),
    .pa_wdata_o(pa_wdata_o),
    .pa_rdata_i(pa_rdata_i),
    .pa_ack_i(pa_ack_i)
  );

  stall_timer #(.TICK_CYCLES(TICK_CYCLES)) u_stall (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .active_i(s_q.rx_act),
    .smp_i(s_q.smp),
    .count_i(s_q.rx_cnt),
    .tmo_o(stall_tmo)
  );

  assign op.req = s_q.op_req;
  assign op.we = s_q.op_we;
  assign op.addr = s_q.op_addr;
  assign op.wdata = s_q.op_wdata;

  // ****************************************
  // Next state
  // ****************************************
  logic acc_en;
  logic acc_we;
  logic [AW-1:0] acc_addr;
  logic [31:0] acc_wd;
  seq_state_t nxt;
  logic [7:0] net_off;
  logic [2:0] widx;
  logic net_hit;
  logic [SIZE_W-1:0] cnt_now;
  logic rx_end;
  op_t req_op;

  always_comb begin
    s_d = s_q;
    s_d.op_req = 1'b0;
    s_d.ack = 1'b0;
    s_d.smp = 1'b0;
    acc_en = 1'b0;
    acc_we = 1'b1;
    acc_addr = CORE_RST;
    acc_wd = WORD_ZERO;
    nxt = s_q.st;
    net_off = wb_adr_i - WB_NET_BASE;
    widx = net_off[4:2];
    net_hit = (wb_adr_i >= WB_NET_BASE) && (wb_adr_i < WB_NET_END);
    cnt_now = {op.rdata[CNT_HI_W-1:0], s_q.rx_lo};
    rx_end = 1'b0;
    req_op = op_t'(wb_dat_i[2:0]);

    if (s_q.trun) begin
      s_d.timer = s_q.timer + 32'h0000_0001;
    end

    // Bus slave: ack one cycle after the request, then drop
    if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.rdata = WORD_ZERO;
      if (wb_we_i) begin
        if (wb_adr_i == WB_CTRL && s_q.st == S_IDLE && wb_sel_i[0]) begin
          s_d.verify = wb_dat_i[CTRL_VERIFY_BIT];
          if (req_op == OP_SEND || req_op == OP_RECV || req_op == OP_DUPLEX || req_op == OP_INIT) begin
            s_d.rej = 1'b0;
            s_d.tmo = 1'b0;
            s_d.vfail = 1'b0;
            s_d.tx_done = (req_op == OP_RECV);
            s_d.rx_done = (req_op == OP_SEND);
            s_d.mode = req_op;
            s_d.idx = '0;
            s_d.rx_cnt = '0;
            s_d.timer = '0;
            s_d.trun = (req_op != OP_INIT);
            if (req_op != OP_INIT && (s_q.size == '0 ||
                (req_op != OP_RECV && (s_q.pkt == '0 || s_q.pkt > PKT_MAX)))) begin
              s_d.rej = 1'b1;
              s_d.trun = 1'b0;
              s_d.istat[IRQ_REJ] = 1'b1;
            end else if (req_op == OP_INIT) begin
              s_d.st = S_RST_ON;
            end else if (req_op == OP_RECV) begin
              s_d.st = S_U_RST;
            end else begin
              s_d.st = S_U_TXL;
            end
          end
        end else if (wb_adr_i == WB_SIZE_LO) begin
          s_d.size[CNT_LO_W-1:0] = merge(s_q.size[CNT_LO_W-1:0], wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == WB_SIZE_HI) begin
          s_d.size[SIZE_W-1:CNT_LO_W] = CNT_HI_W'(merge({22'h0, s_q.size[SIZE_W-1:CNT_LO_W]}, wb_dat_i, wb_sel_i));
        end else if (wb_adr_i == WB_PKT) begin
          s_d.pkt = PKT_W'(merge({16'h0, s_q.pkt}, wb_dat_i, wb_sel_i));
        end else if (net_hit) begin
          s_d.net[widx] = merge(s_q.net[widx], wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == WB_IRQ_STAT && wb_sel_i[0]) begin
          s_d.istat = s_q.istat & ~wb_dat_i[IRQ_W-1:0];
        end else if (wb_adr_i == WB_IRQ_MASK && wb_sel_i[0]) begin
          s_d.imask = wb_dat_i[IRQ_W-1:0];
        end
      end else begin
        if (wb_adr_i == WB_CTRL) begin
          s_d.rdata = {27'h0, s_q.verify, 1'b0, s_q.mode};
        end else if (wb_adr_i == WB_SIZE_LO) begin
          s_d.rdata = s_q.size[CNT_LO_W-1:0];
        end else if (wb_adr_i == WB_SIZE_HI) begin
          s_d.rdata = {22'h0, s_q.size[SIZE_W-1:CNT_LO_W]};
        end else if (wb_adr_i == WB_PKT) begin
          s_d.rdata = {16'h0, s_q.pkt};
        end else if (net_hit) begin
          s_d.rdata = s_q.net[widx];
        end else if (wb_adr_i == WB_STATUS) begin
          s_d.rdata = {20'h0, s_q.st, 1'b0, s_q.vfail, s_q.tmo, s_q.rx_done, s_q.tx_done, s_q.rej,
                       s_q.st != S_IDLE};
        end else if (wb_adr_i == WB_IRQ_STAT) begin
          s_d.rdata = {28'h0, s_q.istat};
        end else if (wb_adr_i == WB_IRQ_MASK) begin
          s_d.rdata = {28'h0, s_q.imask};
        end else if (wb_adr_i == WB_TIMER) begin
          s_d.rdata = s_q.timer;
        end
      end
    end

    // ****************************************
    // Sequence
    // ****************************************
    case (s_q.st)
      S_IDLE: begin
        acc_en = 1'b0;
      end
      S_RST_ON: begin
        acc_en = 1'b1;
        acc_wd = WORD_ONE;
        nxt = S_PARAM;
      end
      S_PARAM: begin
        acc_en = 1'b1;
        acc_addr = CORE_NET_BASE + AW'({s_q.idx, 2'b00});
        acc_wd = s_q.net[s_q.idx];
        nxt = (s_q.idx == 3'(NET_N - 1)) ? S_RST_OFF : S_PARAM;
      end
      S_RST_OFF: begin
        acc_en = 1'b1;
        nxt = S_POLL_INIT;
      end
      S_POLL_INIT: begin
        acc_en = 1'b1;
        acc_we = 1'b0;
        acc_addr = CORE_CMD;
        nxt = op.rdata[BUSY_BIT] ? S_POLL_INIT : S_IDLE;
      end
      S_U_TXL: begin
        acc_en = 1'b1;
        acc_addr = USER_TXL;
        acc_wd = s_q.size[CNT_LO_W-1:0];
        nxt = S_U_TXH;
      end
      S_U_TXH: begin
        acc_en = 1'b1;
        acc_addr = USER_TXH;
        acc_wd = {22'h0, s_q.size[SIZE_W-1:CNT_LO_W]};
        nxt = S_U_RST;
      end
      S_U_RST: begin
        acc_en = 1'b1;
        acc_addr = USER_RST;
        acc_wd = WORD_ONE;
        nxt = S_U_CMD;
      end
      S_U_CMD: begin
        acc_en = 1'b1;
        acc_addr = USER_CMD;
        acc_wd = (s_q.verify && s_q.mode != OP_SEND) ? CMD_VERIFY : WORD_ZERO;
        nxt = (s_q.mode == OP_RECV) ? S_RD_RXL : S_C_PKL;
      end
      S_C_PKL: begin
        acc_en = 1'b1;
        acc_addr = CORE_PKL;
        acc_wd = {16'h0, s_q.pkt};
        nxt = S_C_TDL;
      end
      S_C_TDL: begin
        acc_en = 1'b1;
        acc_addr = CORE_TDL;
        acc_wd = s_q.size[CNT_LO_W-1:0];
        nxt = S_C_TDH;
      end
      S_C_TDH: begin
        acc_en = 1'b1;
        acc_addr = CORE_TDH;
        acc_wd = {22'h0, s_q.size[SIZE_W-1:CNT_LO_W]};
        nxt = S_C_SEND;
      end
      S_C_SEND: begin
        acc_en = 1'b1;
        acc_addr = CORE_CMD;
        acc_wd = WORD_ONE;
        nxt = S_RD_BUSY;
      end
      S_RD_BUSY: begin
        acc_en = 1'b1;
        acc_we = 1'b0;
        acc_addr = CORE_CMD;
        if (!s_q.rx_done) begin
          nxt = S_RD_RXL;
        end else begin
          nxt = op.rdata[BUSY_BIT] ? S_RD_BUSY : S_CHECK;
        end
      end
      S_RD_RXL: begin
        acc_en = 1'b1;
        acc_we = 1'b0;
        acc_addr = USER_RXL;
        nxt = S_RD_RXH;
      end
      S_RD_RXH: begin
        acc_en = 1'b1;
        acc_we = 1'b0;
        acc_addr = USER_RXH;
        rx_end = (cnt_now == s_q.size) || s_q.rx_done;
        if (!s_q.tx_done) begin
          nxt = S_RD_BUSY;
        end else begin
          nxt = rx_end ? S_CHECK : S_RD_RXL;
        end
      end
      S_CHECK: begin
        acc_en = 1'b1;
        acc_we = 1'b0;
        acc_addr = USER_CMD;
        nxt = S_IDLE;
      end
      default: begin
        s_d.st = S_IDLE;
      end
    endcase

    if (acc_en) begin
      if (!s_q.pend) begin
        s_d.op_req = 1'b1;
        s_d.pend = 1'b1;
        s_d.op_we = acc_we;
        s_d.op_addr = acc_addr;
        s_d.op_wdata = acc_wd;
      end else if (op.done) begin
        s_d.pend = 1'b0;
        s_d.st = nxt;
        if (s_q.st == S_PARAM) begin
          s_d.idx = s_q.idx + 3'h1;
        end
        if (s_q.st == S_U_CMD && s_q.mode != OP_SEND) begin
          s_d.rx_act = 1'b1;
        end
        if (s_q.st == S_RD_BUSY) begin
          s_d.tx_done = !op.rdata[BUSY_BIT];
          if (s_q.rx_done && !op.rdata[BUSY_BIT]) begin
            s_d.trun = 1'b0;
          end
        end
        if (s_q.st == S_RD_RXL) begin
          s_d.rx_lo = op.rdata;
        end
        if (s_q.st == S_RD_RXH) begin
          s_d.rx_cnt = cnt_now;
          s_d.smp = 1'b1;
          if (cnt_now == s_q.size && !s_q.rx_done) begin
            s_d.rx_done = 1'b1;
            s_d.rx_act = 1'b0;
          end
          if (s_q.tx_done && rx_end) begin
            s_d.trun = 1'b0;
          end
        end
        if (s_q.st == S_CHECK) begin
          s_d.vfail = op.rdata[VFAIL_BIT];
          s_d.istat[IRQ_DONE] = 1'b1;
          if (op.rdata[VFAIL_BIT]) begin
            s_d.istat[IRQ_VFAIL] = 1'b1;
          end
        end
        if (s_q.st == S_POLL_INIT && !op.rdata[BUSY_BIT]) begin
          s_d.istat[IRQ_DONE] = 1'b1;
        end
      end
    end

    if (stall_tmo && s_q.rx_act && !s_q.rx_done) begin
      s_d.rx_done = 1'b1;
      s_d.rx_act = 1'b0;
      s_d.tmo = 1'b1;
      s_d.istat[IRQ_TMO] = 1'b1;
    end

    s_d.irq = |(s_d.istat & s_d.imask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign irq_o = s_q.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_raised: assert property (s_q.st == S_RST_ON && s_q.op_req |-> s_q.op_we && s_q.op_addr == CORE_RST
    && s_q.op_wdata == WORD_ONE)
    else $error("core reset not raised first");
  a_param_writes: assert property (s_q.st == S_PARAM && s_q.op_req |-> s_q.op_we
    && s_q.op_wdata == s_q.net[s_q.idx])
    else $error("wrong parameter written");
  a_reset_release: assert property ($rose(s_q.st == S_POLL_INIT) |-> $past(s_q.st) == S_RST_OFF)
    else $error("init poll without reset release");
  a_init_poll: assert property (s_q.st == S_POLL_INIT && s_q.pend && op.done && op.rdata[BUSY_BIT]
    |=> s_q.st == S_POLL_INIT)
    else $error("left init poll while busy");
  a_send_cmd: assert property (s_q.st == S_C_SEND && s_q.op_req |-> s_q.op_addr == CORE_CMD
    && s_q.op_wdata == WORD_ONE && $past(s_q.st, 2) == S_C_TDH)
    else $error("bad send command");
  a_user_cmd: assert property (s_q.st == S_U_CMD && s_q.op_req |-> s_q.op_addr == USER_CMD
    && (s_q.op_wdata == CMD_VERIFY || s_q.op_wdata == WORD_ZERO))
    else $error("bad user command");
  a_both_ended: assert property (s_q.st == S_CHECK |-> s_q.tx_done && s_q.rx_done)
    else $error("check before both directions ended");
  a_reject_quiet: assert property (s_q.rej && $rose(s_q.rej) |-> s_q.st == S_IDLE ##1 (!s_q.op_req)[*2])
    else $error("rejected run touched registers");
  a_rx_count_done: assert property (s_q.st == S_RD_RXH && s_q.pend && op.done && cnt_now == s_q.size
    |=> s_q.rx_done)
    else $error("count reached but receive not done");
  a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule : udp_test_sequencer

/* File: tb/core_model.sv */
/* Partner model: offload core and pattern registers.
   Assumes one access at a time, on the sequencer's clock. */
`timescale 1ns/1ps
module core_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [41:0] rx_lim_i,
  output logic [31:0] rdata_o,
  output logic ack_o
);
  import seq_pkg::*;
  int busy = 0;
  logic [41:0] rx = 42'h0;
  logic [47:0] wq[$];
  initial ack_o = 1'b0;
  initial rdata_o = 32'h0;
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    // Idle bus toggles so stale data never looks valid
    rdata_o <= ~rdata_o;
    if (busy > 0) busy <= busy - 1;
    if (rx < rx_lim_i) rx <= rx + 42'h1;
    if (req_i && !ack_o && $urandom_range(1, 0)) begin
      ack_o <= 1'b1;
      if (we_i) begin
        wq.push_back({addr_i, wdata_i});
        if (addr_i == CORE_CMD || (addr_i == CORE_RST && wdata_i == 32'h0)) busy <= 20;
        if (addr_i == USER_CMD) rx <= 42'h0;
      end else if (addr_i == CORE_CMD) rdata_o <= {31'h0, busy > 0};
      else if (addr_i == USER_RXL) rdata_o <= rx[31:0];
      else if (addr_i == USER_RXH) rdata_o <= {22'h0, rx[41:32]};
      else rdata_o <= 32'h0;
    end
  end
endmodule : core_model

/* File: tb/udp_test_sequencer_tb.sv */
/* Self-checking bench for the sequencer.
   Assumes core_model answers the partner port. */
`timescale 1ns/1ps
module udp_test_sequencer_tb;
  import seq_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, p_req, p_we, p_ack;
  logic [7:0] adr = 8'h0;
  logic [31:0] dat = 32'h0, dat_o, rd, p_wd, p_rd, sz;
  logic [15:0] p_adr;
  logic [41:0] rx_lim = 42'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] imk = 32'hF, t0;
  logic [31:0] net[NET_N];
  logic [15:0] seq_exp[8] = '{USER_TXL, USER_TXH, USER_RST, USER_CMD, CORE_PKL, CORE_TDL, CORE_TDH, CORE_CMD};
  int miscompares = 0, total_checks = 0;
  always #5 clk_i = ~clk_i;
  udp_test_sequencer #(.TICK_CYCLES(10)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .pa_req_o(p_req), .pa_we_o(p_we), .pa_addr_o(p_adr), .pa_wdata_o(p_wd),
    .pa_rdata_i(p_rd), .pa_ack_i(p_ack), .irq_o(irq));
  core_model pm (.clk_i(clk_i), .req_i(p_req), .we_i(p_we), .addr_i(p_adr), .wdata_i(p_wd),
    .rx_lim_i(rx_lim), .rdata_o(p_rd), .ack_o(p_ack));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  // Start op, wait idle, check masked irq status, then clear it
  task automatic run(input logic [31:0] ctrl, input logic [31:0] msk, input logic [31:0] exp);
    pm.wq.delete();
    wb(1'b1, WB_CTRL, ctrl);
    do wb(1'b0, WB_STATUS, 32'h0); while (rd[0] !== 1'b0);
    wb(1'b0, WB_IRQ_STAT, 32'h0);
    chk(rd & msk, exp);
    chk(irq, |(rd & imk));
    wb(1'b1, WB_IRQ_STAT, 32'hF);
  endtask : run
  task automatic finish_test;
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial begin
    #300us;
    miscompares++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h5c8c748b));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, WB_IRQ_MASK, imk);
    for (int i = 0; i < NET_N; i++) begin
      net[i] = $urandom;
      wb(1'b1, WB_NET_BASE + 8'(4 * i), net[i]);
    end
    run(32'h1, 32'h1, 32'h1);
    chk(pm.wq.size(), 32'd9);
    for (int i = 0; i < NET_N; i++) chk(pm.wq[i + 1], {CORE_NET_BASE + 16'(4 * i), net[i]});
    chk(pm.wq[0], {CORE_RST, WORD_ONE});
    chk(pm.wq[8], {CORE_RST, WORD_ZERO});
    chk(irq, 1'b0);
    sz = 32'h1 + $urandom_range(19, 0);
    // Byte 0 only: upper bytes must not land
    sel <= 4'h1;
    wb(1'b1, WB_SIZE_LO, 32'hFFFF_FF00 | sz);
    sel <= 4'hF;
    wb(1'b1, WB_SIZE_HI, 32'h0);
    wb(1'b1, WB_PKT, 32'h8);
    run(32'h2, 32'h1, 32'h1);
    for (int i = 0; i < 8; i++) chk(pm.wq[i][47:32], seq_exp[i]);
    chk(pm.wq[7][31:0], WORD_ONE);
    chk(pm.wq[0], {USER_TXL, sz});
    chk(pm.wq[3], {USER_CMD, WORD_ZERO});
    chk(pm.wq[4], {CORE_PKL, 32'h0000_0008});
    chk(pm.wq[5], {CORE_TDL, sz});
    rx_lim <= 42'(sz);
    run(32'h13, 32'h7, 32'h1);
    chk(pm.wq[1], {USER_CMD, CMD_VERIFY});
    wb(1'b0, WB_TIMER, 32'h0);
    t0 = rd;
    wb(1'b0, WB_TIMER, 32'h0);
    chk(rd, t0);
    chk(t0 != 32'h0, 1'b1);
    rx_lim <= 42'(sz - 32'h1);
    run(32'h3, 32'h2, 32'h2);
    rx_lim <= 42'(sz);
    run(32'h4, 32'h3, 32'h1);
    chk(pm.wq[0], {USER_TXL, sz});
    chk(pm.wq[5], {CORE_TDL, sz});
    wb(1'b1, WB_SIZE_LO, 32'h0);
    run(32'h2, 32'h8, 32'h8);
    chk(pm.wq.size(), 32'd0);
    imk = 32'h0;
    wb(1'b1, WB_IRQ_MASK, imk);
    run(32'h3, 32'h8, 32'h8);
    chk(irq, 1'b0);
    finish_test();
  end
endmodule : udp_test_sequencer_tb
